// *** logic/ppd_decade.v ***
// five-stage presettable counter module
`timescale 1ns/1ns
`include "ppd_regs.vh"

module ppd_decade #(
    parameter STAGES = `PPD_STAGES
) (
    // clock and reset
    input wire mclk,
    input wire reset,
    // preset control
    input wire load,
    input wire [STAGES-1:0] preset_data_input,
    // counting
    input wire advance,
    input wire decade_mode,
    // stage outputs, bit 0 is the first stage
    output reg [STAGES-1:0] stage_q
);

    // ============================================================
    // serial input of the first stage
    // decade mode feeds back the inverted last stage: ten states
    // own mode is a self-starting five-state ring
    wire ring_in;
    wire serial_in;
    assign ring_in = ~(|stage_q[STAGES-2:0]);
    assign serial_in = decade_mode ? ~stage_q[STAGES-1] : ring_in;

    // ============================================================
    // one flop per stage, each preset from its own data input
    genvar gi;
    generate
        for (gi = 0; gi < STAGES; gi = gi + 1) begin : g_stage
            wire shift_in;
            if (gi == 0) begin : g_first
                assign shift_in = serial_in;
            end else begin : g_rest
                assign shift_in = stage_q[gi-1];
            end
            always @(posedge mclk or posedge reset) begin
                if (reset) begin
                    stage_q[gi] <= 1'b0;
                end else if (load) begin
                    stage_q[gi] <= preset_data_input[gi];
                end else if (advance) begin
                    stage_q[gi] <= shift_in;
                end
            end
        end
    endgenerate

endmodule // ppd_decade

// *** logic/ppd_divider.v ***
// programmable preset divide-by-n for the synthesizer loop
`timescale 1ns/1ns
`include "ppd_regs.vh"

module ppd_divider #(
    parameter SEL_W = `PPD_SEL_W,
    parameter RATIO_W = `PPD_RATIO_W,
    parameter [3:0] ONESHOT_PULSES = `PPD_ONESHOT_PULSES
) (
    // clock and reset
    input wire mclk,
    input wire reset,
    // mixer-derived pulse train, asynchronous
    input wire mixer_pulse_in,
    // frequency selectors, bcd, asynchronous
    input wire [SEL_W-1:0] units_sel,
    input wire [SEL_W-1:0] tens_sel,
    input wire [SEL_W-1:0] hund_sel,
    // loop side
    output reg loop_reload_pulse,
    output reg first_detect_out,
    output reg final_detect_out,
    // status
    output reg [RATIO_W-1:0] division_ratio,
    output reg [`PPD_STAGE_MSB:0] units_state,
    output reg [`PPD_STAGE_MSB:0] tens_state,
    output reg [`PPD_STAGE_MSB:0] hund_state
);

    // ============================================================
    // johnson code of a state index: 0 = 00000, 5 = 11111, 9 = 10000
    function [`PPD_STAGE_MSB:0] johnson_code;
        input [3:0] idx;
        integer i;
        integer k;
        begin
            k = idx;
            johnson_code = `PPD_STATE_RST;
            for (i = 0; i < `PPD_STAGES; i = i + 1) begin
                if (k <= 5) begin
                    johnson_code[i] = (i < k);
                end else begin
                    johnson_code[i] = (i >= k - 5);
                end
            end
        end
    endfunction

    // ============================================================
    // clamp an out-of-range bcd digit to nine
    function [3:0] clamp_digit;
        input [3:0] d;
        begin
            if (d > `PPD_SEL_MAX) begin
                clamp_digit = `PPD_SEL_MAX;
            end else begin
                clamp_digit = d;
            end
        end
    endfunction

    // ============================================================
    // input synchronisers
    reg mix_s1_q;
    reg mix_s2_q;
    reg mix_s3_q;
    reg [SEL_W-1:0] units_s1_q;
    reg [SEL_W-1:0] units_s2_q;
    reg [SEL_W-1:0] tens_s1_q;
    reg [SEL_W-1:0] tens_s2_q;
    reg [SEL_W-1:0] hund_s1_q;
    reg [SEL_W-1:0] hund_s2_q;

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            mix_s1_q <= 1'b0;
            mix_s2_q <= 1'b0;
            mix_s3_q <= 1'b0;
            units_s1_q <= `PPD_SEL_RST;
            units_s2_q <= `PPD_SEL_RST;
            tens_s1_q <= `PPD_SEL_RST;
            tens_s2_q <= `PPD_SEL_RST;
            hund_s1_q <= `PPD_SEL_RST;
            hund_s2_q <= `PPD_SEL_RST;
        end else begin
            mix_s1_q <= mixer_pulse_in;
            mix_s2_q <= mix_s1_q;
            mix_s3_q <= mix_s2_q;
            units_s1_q <= units_sel;
            units_s2_q <= units_s1_q;
            tens_s1_q <= tens_sel;
            tens_s2_q <= tens_s1_q;
            hund_s1_q <= hund_sel;
            hund_s2_q <= hund_s1_q;
        end
    end

    // leading edge of an input pulse
    wire count_stb;
    assign count_stb = mix_s2_q & ~mix_s3_q;

    // ============================================================
    // selector digits and preset codes
    // the units and tens modules count up to index nine, so each is preset to
    // nine minus its digit and reaches the decode after that many
    wire [3:0] units_digit;
    wire [3:0] tens_digit;
    wire [3:0] hund_digit;
    wire hund_odd;
    wire [3:0] units_idx;
    wire [3:0] tens_idx;
    wire [`PPD_STAGE_MSB:0] units_preset;
    wire [`PPD_STAGE_MSB:0] tens_preset;
    wire [`PPD_STAGE_MSB:0] hund_preset;

    assign units_digit = clamp_digit(units_s2_q[3:0]);
    assign tens_digit = clamp_digit(tens_s2_q[3:0]);
    assign hund_digit = clamp_digit(hund_s2_q[3:0]);
    assign hund_odd = hund_digit[0];
    assign units_idx = `PPD_TERM_INDEX - units_digit;
    assign tens_idx = `PPD_TERM_INDEX - tens_digit;
    assign units_preset = johnson_code(units_idx);
    assign tens_preset = johnson_code(tens_idx);
    assign hund_preset = hund_odd ? `PPD_HUND_ODD_PRESET
                                  : `PPD_HUND_EVEN_PRESET;

    // ============================================================
    // reload and one-shot control
    reg reload_q;
    reg [3:0] oneshot_cnt_q;
    wire oneshot_gate1_n;
    wire hund_load;

    // first gate of the one-shot is low while it is triggered
    assign oneshot_gate1_n = ~reload_q;
    assign hund_load = ~oneshot_gate1_n;

    // ============================================================
    // counter modules
    wire [`PPD_STAGE_MSB:0] units_q;
    wire [`PPD_STAGE_MSB:0] tens_q;
    wire [`PPD_STAGE_MSB:0] hund_q;
    wire units_adv;
    wire tens_adv;
    wire hund_adv;
    wire first_det;
    wire final_det;

    // the units module is stepped by every input pulse
    assign units_adv = count_stb;
    // tens steps when the units inverted last stage rises
    assign tens_adv = count_stb & units_q[4] & ~units_q[3];
    // hundreds steps as each first-detect window is closed
    assign hund_adv = count_stb & first_det;

    ppd_decade #(
        .STAGES(`PPD_STAGES)
    ) u_units (
        .mclk(mclk),
        .reset(reset),
        .load(reload_q),
        .preset_data_input(units_preset),
        .advance(units_adv),
        .decade_mode(1'b1),
        .stage_q(units_q)
    );

    ppd_decade #(
        .STAGES(`PPD_STAGES)
    ) u_tens (
        .mclk(mclk),
        .reset(reset),
        .load(reload_q),
        .preset_data_input(tens_preset),
        .advance(tens_adv),
        .decade_mode(1'b1),
        .stage_q(tens_q)
    );

    ppd_decade #(
        .STAGES(`PPD_STAGES)
    ) u_hund (
        .mclk(mclk),
        .reset(reset),
        .load(hund_load),
        .preset_data_input(hund_preset),
        .advance(hund_adv),
        .decade_mode(1'b1),
        .stage_q(hund_q)
    );

    // ============================================================
    // terminal detect gates
    // first gate decodes index nine of both modules: stage four low,
    // last stage high, so all four nor inputs are low
    wire units_st4_in;
    wire units_st5n_in;
    wire tens_st4_in;
    wire tens_st5n_in;
    assign units_st4_in = units_q[3];
    assign units_st5n_in = ~units_q[4];
    assign tens_st4_in = tens_q[3];
    assign tens_st5n_in = ~tens_q[4];
    assign first_det = ~(units_st4_in | units_st5n_in |
                         tens_st4_in | tens_st5n_in);

    // second gate: inverted first detect and hundreds stages one and five
    wire first_det_n;
    wire hund_st1n_in;
    wire hund_st5n_in;
    assign first_det_n = ~first_det;
    assign hund_st1n_in = ~hund_q[0];
    assign hund_st5n_in = ~hund_q[4];
    assign final_det = ~(first_det_n | hund_st1n_in | hund_st5n_in);

    // ============================================================
    // reload pulse: one cycle per final detect; the decode stays high until
    // the presets load, so the ~reload_q term keeps it from firing twice per period
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            reload_q <= 1'b1;
        end else begin
            reload_q <= final_det & ~reload_q;
        end
    end

    // ============================================================
    // reload one-shot, width counted in input pulses
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            oneshot_cnt_q <= `PPD_ONESHOT_RST;
            loop_reload_pulse <= 1'b0;
        end else if (reload_q) begin
            oneshot_cnt_q <= ONESHOT_PULSES;
            loop_reload_pulse <= 1'b1;
        end else if (count_stb && oneshot_cnt_q != `PPD_ONESHOT_RST) begin
            oneshot_cnt_q <= oneshot_cnt_q - 4'h1;
            if (oneshot_cnt_q == 4'h1) begin
                loop_reload_pulse <= 1'b0;
            end
        end
    end

    // ============================================================
    // ratio implied by the settings
    wire [RATIO_W-1:0] units_term;
    wire [RATIO_W-1:0] tens_wide;
    wire [RATIO_W-1:0] tens_term;
    wire [RATIO_W-1:0] hund_term;
    wire [RATIO_W-1:0] ratio_d;
    assign units_term = {{(RATIO_W-4){1'b0}}, units_digit};
    assign tens_wide = {{(RATIO_W-4){1'b0}}, tens_digit};
    assign tens_term = (tens_wide << 3) + (tens_wide << 1);
    assign hund_term = hund_odd ? `PPD_RATIO_ODD : {RATIO_W{1'b0}};
    assign ratio_d = `PPD_RATIO_BASE + hund_term + tens_term
                     + units_term;

    // ============================================================
    // registered outputs
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            first_detect_out <= 1'b0;
            final_detect_out <= 1'b0;
            division_ratio <= `PPD_RATIO_RST;
            units_state <= `PPD_STATE_RST;
            tens_state <= `PPD_STATE_RST;
            hund_state <= `PPD_STATE_RST;
        end else begin
            first_detect_out <= first_det;
            final_detect_out <= final_det;
            division_ratio <= ratio_d;
            units_state <= units_q;
            tens_state <= tens_q;
            hund_state <= hund_q;
        end
    end

endmodule // ppd_divider

// *** shared/ppd_regs.vh ***
// constants for the programmable preset divider
`ifndef PPD_REGS_VH
`define PPD_REGS_VH

// ============================================================
// counter module geometry
`define PPD_STAGES 5
`define PPD_STAGE_MSB 4
`define PPD_SEL_W 4
`define PPD_RATIO_W 10

// ============================================================
// selector decoding
`define PPD_SEL_MAX 4'h9
`define PPD_TERM_INDEX 4'h9
`define PPD_JOHNSON_HALF 4'h5

// ============================================================
// reset and preset values
`define PPD_STATE_RST 5'h00
`define PPD_HUND_EVEN_PRESET 5'h00
`define PPD_HUND_ODD_PRESET 5'h10
`define PPD_SEL_RST 4'h0
`define PPD_RATIO_RST 10'h1F4

// ============================================================
// division ratio terms
`define PPD_RATIO_BASE 10'h1F4
`define PPD_RATIO_ODD 10'h064

// ============================================================
// reload one-shot width, in input pulses
`define PPD_ONESHOT_PULSES 4'h2
`define PPD_ONESHOT_RST 4'h0

`endif

// *** tb/ppd_chk.sv ***
// assertion checker bound to the preset divider top
`timescale 1ns/1ns
module ppd_chk #(
    parameter SEL_W = 4,
    parameter RATIO_W = 10
) (
    // clock and reset
    input wire mclk,
    input wire reset,
    // selectors
    input wire [SEL_W-1:0] units_sel,
    input wire [SEL_W-1:0] tens_sel,
    input wire [SEL_W-1:0] hund_sel,
    // outputs
    input wire loop_reload_pulse,
    input wire first_detect_out,
    input wire final_detect_out,
    input wire [RATIO_W-1:0] division_ratio,
    input wire [4:0] units_state,
    input wire [4:0] tens_state,
    input wire [4:0] hund_state
);
    // ========================================
    // helper logic
    reg [2:0] calm_q;
    reg [11:0] sel_q;
    reg [4:0] u_q;
    reg [4:0] t_q;
    reg [4:0] h_q;
    reg dec_q;
    reg rl1_q;
    reg rl2_q;
    // reload rose one edge before the states show the preset
    wire ld_w = rl1_q & ~rl2_q;
    wire dec_w = units_state[4] & ~units_state[3]
        & tens_state[4] & ~tens_state[3];
    function [3:0] dg(input [3:0] d);
        dg = d > 4'h9 ? 4'h9 : d;
    endfunction
    function [9:0] want(input [3:0] h, input [3:0] t, input [3:0] u);
        want = 10'h1F4 + (dg(h) & 4'h1) * 10'h064 + dg(t) * 10'h00A + dg(u);
    endfunction
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            calm_q <= 3'h0;
            sel_q <= 12'h000;
            u_q <= 5'h00;
            t_q <= 5'h00;
            h_q <= 5'h00;
            dec_q <= 1'b0;
            rl1_q <= 1'b0;
            rl2_q <= 1'b0;
        end else begin
            rl1_q <= loop_reload_pulse;
            rl2_q <= rl1_q;
            sel_q <= {hund_sel, tens_sel, units_sel};
            if (sel_q != {hund_sel, tens_sel, units_sel})
                calm_q <= 3'h0;
            else if (calm_q != 3'h7)
                calm_q <= calm_q + 3'h1;
            u_q <= units_state;
            t_q <= tens_state;
            h_q <= hund_state;
            dec_q <= dec_w;
        end
    end
    // ========================================
    // properties
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    AST_RATIO: assert property (
        calm_q == 3'h7 && sel_q == {hund_sel, tens_sel, units_sel}
            |-> division_ratio == want(hund_sel, tens_sel, units_sel))
        else $error("ratio output disagrees with selectors");
    AST_FIRST: assert property (
        dec_w == dec_q |-> first_detect_out == dec_w)
        else $error("first detect disagrees with stage decode");
    AST_FINAL: assert property (
        $rose(final_detect_out) |-> dec_w && hund_state == 5'h1F)
        else $error("final detect without all three inputs");
    AST_RELOAD: assert property (
        $rose(final_detect_out) |-> ##[1:3] $rose(loop_reload_pulse))
        else $error("final detect did not fire the reload");
    AST_FINAL_LEN: assert property (
        $rose(final_detect_out) |=> ##[0:2] !final_detect_out)
        else $error("final detect stays high too long");
    AST_HUND_PRESET: assert property (
        $rose(loop_reload_pulse) |=> hund_state[3:0] == 4'h0)
        else $error("hundreds preset touched a stage other than five");
    AST_ONESHOT: assert property (
        $rose(loop_reload_pulse) |-> loop_reload_pulse [*3])
        else $error("reload pulse shorter than an input pulse");
    AST_UNITS_STEP: assert property (
        units_state != u_q && !ld_w
            |-> units_state == {u_q[3:0], ~u_q[4]})
        else $error("units module left its ten-state ring");
    AST_TENS_STEP: assert property (
        tens_state != t_q && !ld_w
            |-> u_q == 5'h10 && tens_state == {t_q[3:0], ~t_q[4]})
        else $error("tens stepped without a units wrap");
    AST_HUND_STEP: assert property (
        hund_state != h_q && !ld_w
            |-> dec_q && !dec_w && hund_state == {h_q[3:0], ~h_q[4]})
        else $error("hundreds stepped outside a detect window end");
endmodule // ppd_chk

bind ppd_divider ppd_chk #(.SEL_W(SEL_W), .RATIO_W(RATIO_W)) i_chk (
    .mclk(mclk), .reset(reset), .units_sel(units_sel),
    .tens_sel(tens_sel), .hund_sel(hund_sel),
    .loop_reload_pulse(loop_reload_pulse),
    .first_detect_out(first_detect_out),
    .final_detect_out(final_detect_out),
    .division_ratio(division_ratio), .units_state(units_state),
    .tens_state(tens_state), .hund_state(hund_state)
);

// *** tb/ppd_mixer_src.sv ***
// mixer pulse train source facing the divider input
`timescale 1ns/1ns
module ppd_mixer_src (
    // clock and reset
    input wire mclk,
    input wire reset,
    // pacing
    input wire run,
    input wire [3:0] low_len,
    // pulse train
    output reg mixer_pulse_in,
    output reg [15:0] n_sent
);
    reg [3:0] cnt_q;
    // high four cycles, low low_len cycles, so no pulse is lost
    always @(negedge mclk or posedge reset) begin
        if (reset) begin
            mixer_pulse_in <= 1'b0;
            cnt_q <= 4'h0;
            n_sent <= 16'h0000;
        end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end else if (mixer_pulse_in) begin
            mixer_pulse_in <= 1'b0;
            cnt_q <= low_len - 4'h1;
        end else if (run) begin
            mixer_pulse_in <= 1'b1;
            n_sent <= n_sent + 16'h0001;
            cnt_q <= 4'h3;
        end
    end
endmodule // ppd_mixer_src

// *** tb/tb.sv ***
// self-checking bench for the programmable preset divider
`timescale 1ns/1ns
`include "ppd_regs.vh"
module tb;
    reg mclk = 1'b0;
    reg reset = 1'b1;
    reg run = 1'b0;
    reg [3:0] low_len = 4'h4;
    reg [3:0] units_sel = 4'h0;
    reg [3:0] tens_sel = 4'h0;
    reg [3:0] hund_sel = 4'h0;
    reg [3:0] eu = 4'h0;
    reg [3:0] et = 4'h0;
    reg [3:0] eh = 4'h0;
    reg [31:0] rng = 32'h00000057;
    reg [15:0] base = 16'h0000;
    reg active = 1'b0;
    integer n_mismatch = 0;
    integer n_compared = 0;
    wire mixer_pulse_in;
    wire [15:0] n_sent;
    wire loop_reload_pulse;
    wire first_detect_out;
    wire final_detect_out;
    wire [9:0] division_ratio;
    wire [4:0] units_state;
    wire [4:0] tens_state;
    wire [4:0] hund_state;

    always #50 mclk = ~mclk;

    ppd_mixer_src i_src (.mclk(mclk), .reset(reset), .run(run),
        .low_len(low_len), .mixer_pulse_in(mixer_pulse_in), .n_sent(n_sent));
    ppd_divider i_dut (.mclk(mclk), .reset(reset),
        .mixer_pulse_in(mixer_pulse_in), .units_sel(units_sel),
        .tens_sel(tens_sel), .hund_sel(hund_sel),
        .loop_reload_pulse(loop_reload_pulse),
        .first_detect_out(first_detect_out),
        .final_detect_out(final_detect_out), .division_ratio(division_ratio),
        .units_state(units_state), .tens_state(tens_state),
        .hund_state(hund_state));

    // ========================================
    // expectation helpers
    function [31:0] xs(input [31:0] s);
        reg [31:0] x;
        begin
            x = s ^ (s << 13);
            x = x ^ (x >> 17);
            xs = x ^ (x << 5);
        end
    endfunction
    function [3:0] dg(input [3:0] d);
        dg = d > 4'h9 ? 4'h9 : d;
    endfunction
    function [4:0] jcode(input [3:0] k);
        jcode = k <= 4'h5 ? 5'h1F >> (4'h5 - k) : 5'h1F << (k - 4'h5);
    endfunction
    function [9:0] eratio(input [3:0] h, input [3:0] t, input [3:0] u);
        eratio = 10'h1F4 + (dg(h) & 4'h1) * 10'h064 + dg(t) * 10'h00A + dg(u);
    endfunction

    task check(input [15:0] seen, input [15:0] want);
        begin
            n_compared = n_compared + 1;
            if (seen !== want) begin
                n_mismatch = n_mismatch + 1;
                $display("mismatch at %0t: saw %h wanted %h",
                    $time, seen, want);
            end
        end
    endtask
    task results;
        begin
            $display("compared %0d mismatched %0d", n_compared, n_mismatch);
            if (n_mismatch == 0 && n_compared > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask

    // ========================================
    // detect position within each hundred pulses
    always @(posedge first_detect_out)
        if (active)
            check((n_sent - base) % 16'h0064,
                16'h000A * dg(et) + dg(eu));

    // one-shot ends on the second input pulse after a reload
    always @(negedge loop_reload_pulse)
        if (active)
            check(n_sent - base, `PPD_ONESHOT_PULSES);

    // ========================================
    // main sequence, one measured period per setting except the last two chosen
    initial begin : main
        integer i;
        reg [11:0] s;
        repeat (16) @(negedge mclk);
        reset = 1'b0;
        repeat (4) @(negedge mclk);
        run = 1'b1;
        for (i = 0; i < 8; i = i + 1) begin
            @(posedge loop_reload_pulse);
            if (active)
                check(n_sent - base, eratio(eh, et, eu));
            base = n_sent;
            {eh, et, eu} = {hund_sel, tens_sel, units_sel};
            active = 1'b1;
            // states show the preset one edge after the load edge
            repeat (2) @(negedge mclk);
            check(units_state, jcode(4'h9 - dg(eu)));
            check(tens_state, jcode(4'h9 - dg(et)));
            check(hund_state, {dg(eh) & 4'h1, 4'h0});
            check(division_ratio, eratio(eh, et, eu));
            rng = xs(rng);
            case (i)
                0: s = 12'h199;
                1: s = 12'h899;
                2: s = 12'hFFF;
                3: s = 12'h090;
                default: s = {rng[11:8] % 4'hA, rng[7:4] % 4'hA,
                    rng[3:0] % 4'hA};
            endcase
            {hund_sel, tens_sel, units_sel} = s;
            low_len = 4'h4 + rng[13];
        end
        results;
    end

    initial begin
        #8000000;
        n_mismatch = n_mismatch + 1;
        results;
    end
endmodule // tb
